/* File: dimc_pkg.sv */
/*
 * package of the converter input mode control, plus the small level synchroniser
 * that the main module uses for every pin and every toggle crossing into clk_sys.
 * assumes: the synchronised inputs change slowly compared with clk_sys (40 ns).
 */
// ------------------------------------------------------------
// shared constants and types
// ------------------------------------------------------------
package dimc_pkg;
    localparam int          CODE_W     = 8;        // converter word width
    localparam logic [7:0]  MID_SCALE  = 8'h80;    // zero differential output
    localparam logic [7:0]  NEG_FS     = 8'h00;    // negative full scale code
    localparam logic [7:0]  POS_FS     = 8'hff;    // positive full scale code
    localparam logic [3:0]  WORD_BITS  = 4'h8;     // bits in one serial word
    localparam logic [1:0]  BOOT_LAST  = 2'h3;     // settle cycles before mode is trusted
    localparam int          PIN_W      = 13;       // width of the pin bundle
    localparam int          TOG_W      = 2;        // width of the toggle bundle

    typedef enum logic [1:0] {
        DIMC_NVM,
        DIMC_PARALLEL,
        DIMC_JTAG_DIRECT,
        DIMC_SPI
    } dimc_mode_t;

    typedef struct packed {
        logic       src_sel;     // source select level
        logic       spi_en;      // serial port enable level
        logic       cs;          // chip select level
        logic       sclk;        // serial port clock level
        logic       sdata;       // serial port data level
        logic [7:0] data;        // parallel data, bit 0 is the lsb
    } dimc_pins_t;

    typedef struct packed {
        logic load;              // flips on each complete direct load
        logic prog;              // flips on each program command
    } dimc_tog_t;
endpackage : dimc_pkg

// ------------------------------------------------------------
// two-flop synchroniser
// ------------------------------------------------------------
`timescale 1ns/1ps
module dimc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage is read by the second stage only
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : dimc_sync

/* File: dimc_ctrl.sv */
/*
 * converter input mode control: picks the source of the 8-bit converter code and runs
 * the nonvolatile, parallel, jtag direct and spi loading paths.
 * assumes: the tap controller outside supplies shift-dr / update-dr levels on tck and a
 * reset synchronous to tck; the nonvolatile array presents its stored code as a level.
 */
`timescale 1ns/1ps
module dimc_ctrl
    import dimc_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      srst,
    input  wire logic                      tck,
    input  wire logic                      tck_rst,
    input  wire logic                      tdi,
    input  wire logic                      jtag_shift_dr,
    input  wire logic                      jtag_update_dr,
    input  wire logic                      direct_load_command,
    input  wire logic                      nvm_program_command,
    input  wire logic                      direct_serial_option,
    input  wire logic                      dac_source_select_pin,
    input  wire logic                      serial_port_enable_pin,
    input  wire logic                      chip_select_pin,
    input  wire logic                      spi_clk_pin,
    input  wire logic                      spi_data_pin,
    input  wire logic [dimc_pkg::CODE_W-1:0] data_bits,
    input  wire logic [dimc_pkg::CODE_W-1:0] nvm_stored_code,
    output logic      [dimc_pkg::CODE_W-1:0] dac_code,
    output dimc_pkg::dimc_mode_t           active_mode,
    output logic                           nvm_prog_req,
    output logic      [dimc_pkg::CODE_W-1:0] nvm_prog_data,
    output logic                           nvm_prog_refused
);
    import dimc_pkg::*;

    // ------------------------------------------------------------
    // jtag shift side, rising tck
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sr;          // serial input shift register
        logic [3:0] cnt;         // bits shifted, saturates above eight
    } dimc_tsh_t;

    typedef struct packed {
        logic [7:0] word;        // serial latch on the jtag side
        logic       load_tog;
        logic       prog_tog;
    } dimc_tup_t;

    dimc_tsh_t tsh_r;
    dimc_tsh_t tsh_nxt;
    dimc_tup_t tup_r;
    dimc_tup_t tup_nxt;

    // shift lsb first, new bits enter at the top
    always_comb begin
        tsh_nxt = tsh_r;
        if (jtag_shift_dr && direct_load_command) begin
            tsh_nxt.sr = {tdi, tsh_r.sr[7:1]};
            if (tsh_r.cnt <= WORD_BITS)
                tsh_nxt.cnt = tsh_r.cnt + 4'h1;
        end else if (jtag_update_dr) begin
            tsh_nxt.cnt = 4'h0;
        end
    end

    always_ff @(posedge tck) begin
        if (tck_rst)
            tsh_r <= '0;
        else
            tsh_r <= tsh_nxt;
    end

    // ------------------------------------------------------------
    // jtag update side, falling tck
    // ------------------------------------------------------------
    // the word is caught on the falling edge, mid update-dr; the converter moves once the toggle has crossed into clk_sys
    always_comb begin
        tup_nxt = tup_r;
        if (jtag_update_dr && direct_load_command && tsh_r.cnt == WORD_BITS) begin
            tup_nxt.word     = tsh_r.sr;
            tup_nxt.load_tog = ~tup_r.load_tog;
        end
        if (jtag_update_dr && nvm_program_command)
            tup_nxt.prog_tog = ~tup_r.prog_tog;
    end

    always_ff @(negedge tck) begin
        if (tck_rst) begin
            tup_r.word     <= MID_SCALE;
            tup_r.load_tog <= 1'b0;
            tup_r.prog_tog <= 1'b0;
        end else begin
            tup_r <= tup_nxt;
        end
    end

    // ------------------------------------------------------------
    // crossings into clk_sys
    // ------------------------------------------------------------
    dimc_pins_t pins_raw;
    dimc_pins_t pins_s;
    dimc_tog_t  tog_raw;
    dimc_tog_t  tog_s;

    assign pins_raw = '{src_sel: dac_source_select_pin, spi_en: serial_port_enable_pin,
                        cs: chip_select_pin, sclk: spi_clk_pin, sdata: spi_data_pin,
                        data: data_bits};
    assign tog_raw  = '{load: tup_r.load_tog, prog: tup_r.prog_tog};

    dimc_sync #(.W(PIN_W)) u_pin_sync (
        .clk      (clk_sys),
        .srst     (srst),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    // the word itself is not synchronised: it stands still from the toggle flip
    // until the next update-dr, which is many clk_sys cycles away at jtag rates
    dimc_sync #(.W(TOG_W)) u_tog_sync (
        .clk      (clk_sys),
        .srst     (srst),
        .async_in (tog_raw),
        .sync_out (tog_s)
    );

    // ------------------------------------------------------------
    // system side state
    // ------------------------------------------------------------
    typedef struct packed {
        dimc_mode_t mode;
        logic [1:0] boot;        // counts settle cycles after reset
        logic       booted;
        logic [7:0] dac;
        logic [7:0] par_latch;
        logic [7:0] ser_latch;
        logic [7:0] spi_sr;
        logic [3:0] spi_cnt;
        logic       cs_d;
        logic       sclk_d;
        dimc_tog_t  tog_d;
        logic       prog_req;
        logic [7:0] prog_data;
        logic       refused;
    } dimc_sys_t;

    dimc_sys_t s_r;
    dimc_sys_t s_nxt;

    logic       cs_rise;
    logic       sclk_rise;
    logic       load_evt;
    logic       prog_evt;
    dimc_mode_t mode_dec;

    assign cs_rise   = pins_s.cs & ~s_r.cs_d;
    assign sclk_rise = pins_s.sclk & ~s_r.sclk_d;
    assign load_evt  = tog_s.load ^ s_r.tog_d.load;
    assign prog_evt  = tog_s.prog ^ s_r.tog_d.prog;

    // spi enable wins, then the stored option, then source select
    always_comb begin
        if (pins_s.spi_en)
            mode_dec = DIMC_SPI;
        else if (direct_serial_option)
            mode_dec = DIMC_JTAG_DIRECT;
        else if (pins_s.src_sel)
            mode_dec = DIMC_PARALLEL;
        else
            mode_dec = DIMC_NVM;
    end

    always_comb begin
        s_nxt          = s_r;
        s_nxt.mode     = mode_dec;
        s_nxt.cs_d     = pins_s.cs;
        s_nxt.sclk_d   = pins_s.sclk;
        s_nxt.tog_d    = tog_s;
        s_nxt.prog_req = 1'b0;
        s_nxt.refused  = 1'b0;
        if (!s_r.booted) begin
            // pins need the synchroniser depth before the mode can be believed
            s_nxt.boot = s_r.boot + 2'h1;
            if (s_r.boot == BOOT_LAST) begin
                s_nxt.booted = 1'b1;
                if (mode_dec == DIMC_NVM)
                    s_nxt.dac = nvm_stored_code;
                else
                    s_nxt.dac = MID_SCALE;
            end
        end else begin
            // spi bits shift while chip select is low
            if (!pins_s.cs && sclk_rise) begin
                s_nxt.spi_sr = {pins_s.sdata, s_r.spi_sr[7:1]};
                if (s_r.spi_cnt <= WORD_BITS)
                    s_nxt.spi_cnt = s_r.spi_cnt + 4'h1;
            end
            if (cs_rise) begin
                s_nxt.spi_cnt = 4'h0;
                // a short or long spi frame leaves the serial latch as it was
                if (s_r.spi_cnt == WORD_BITS) begin
                    s_nxt.ser_latch = s_r.spi_sr;
                    if (s_r.mode == DIMC_SPI)
                        s_nxt.dac = s_r.spi_sr;
                end
                if (s_r.mode == DIMC_PARALLEL) begin
                    s_nxt.par_latch = pins_s.data;
                    s_nxt.dac       = pins_s.data;
                end
            end
            if (load_evt) begin
                s_nxt.ser_latch = tup_r.word;
                if (s_r.mode == DIMC_JTAG_DIRECT)
                    s_nxt.dac = tup_r.word;
            end
            // the nonvolatile mode mirrors the cells, so only reprogramming moves it
            if (s_r.mode == DIMC_NVM)
                s_nxt.dac = nvm_stored_code;
            if (prog_evt) begin
                if (s_r.mode == DIMC_SPI) begin
                    s_nxt.refused = 1'b1;
                end else begin
                    s_nxt.prog_req = 1'b1;
                    if (s_r.mode == DIMC_PARALLEL)
                        s_nxt.prog_data = s_r.par_latch;
                    else
                        s_nxt.prog_data = tup_r.word;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r           <= '0;
            s_r.mode      <= DIMC_NVM;
            s_r.dac       <= MID_SCALE;
            s_r.par_latch <= MID_SCALE;
            s_r.ser_latch <= MID_SCALE;
            s_r.prog_data <= MID_SCALE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // code goes straight to the converter: straight binary, no recoding
    assign dac_code         = s_r.dac;
    assign active_mode      = s_r.mode;
    assign nvm_prog_req     = s_r.prog_req;
    assign nvm_prog_data    = s_r.prog_data;
    assign nvm_prog_refused = s_r.refused;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // system-side checks sample on clk_sys and sleep through srst; the tck-side
    // checks name their own edge and reset, since the two clocks share no phase
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // program commands: refused in spi mode, carried out in parallel (with the latched word) and jtag direct modes
    chk_spi_no_prog: assert property (prog_evt && s_r.booted && s_r.mode == DIMC_SPI
        |=> !nvm_prog_req && nvm_prog_refused) else $error("program accepted in spi mode");
    chk_prog_data_par: assert property (prog_evt && s_r.booted && s_r.mode == DIMC_PARALLEL
        |=> nvm_prog_req && nvm_prog_data == $past(s_r.par_latch)) else $error("bad program data");
    chk_direct_prog: assert property (prog_evt && s_r.booted && s_r.mode == DIMC_JTAG_DIRECT
        |=> nvm_prog_req && !nvm_prog_refused) else $error("direct mode program lost");

    // strobes last one cycle, so the cell writer sees one request per command
    chk_prog_pulse: assert property (nvm_prog_req
        |=> !nvm_prog_req) else $error("program request held longer than one cycle");
    chk_refuse_pulse: assert property (nvm_prog_refused
        |=> !nvm_prog_refused) else $error("refusal held longer than one cycle");

    // parallel port: the synced chip select rise applies the pins, nothing else moves the code
    chk_par_update: assert property (s_r.booted && cs_rise && s_r.mode == DIMC_PARALLEL
        |=> dac_code == $past(pins_s.data)) else $error("parallel code not applied");
    chk_par_hold: assert property (s_r.booted && s_r.mode == DIMC_PARALLEL && !cs_rise
        |=> $stable(dac_code)) else $error("parallel code moved without chip select");

    // nonvolatile mode mirrors the cells, so the cell model shows any reprogramming
    chk_nvm_follow: assert property (s_r.booted && s_r.mode == DIMC_NVM
        |=> dac_code == $past(nvm_stored_code)) else $error("nonvolatile code not shown");

    // power-up code, taken once the pins have passed the synchroniser
    chk_boot_mid: assert property (s_r.boot == BOOT_LAST && !s_r.booted && mode_dec != DIMC_NVM
        |=> dac_code == MID_SCALE) else $error("power-up code not mid scale");
    chk_boot_nvm: assert property (s_r.boot == BOOT_LAST && !s_r.booted && mode_dec == DIMC_NVM
        |=> dac_code == $past(nvm_stored_code)) else $error("power-up code not stored value");

    // spi port: bits enter at the top, only a full word reaches the converter
    chk_spi_bit_order: assert property (s_r.booted && !pins_s.cs && sclk_rise
        |=> s_r.spi_sr[7] == $past(pins_s.sdata)) else $error("spi bit not shifted in at the top");
    chk_spi_load: assert property (s_r.booted && cs_rise && s_r.mode == DIMC_SPI
        && s_r.spi_cnt == WORD_BITS |=> dac_code == $past(s_r.spi_sr)) else $error("spi word not applied");
    chk_spi_bad_len: assert property (s_r.booted && cs_rise && s_r.mode == DIMC_SPI
        && s_r.spi_cnt != WORD_BITS |=> $stable(dac_code)) else $error("short or long spi frame applied");
    chk_spi_hold: assert property (s_r.booted && s_r.mode == DIMC_SPI && !cs_rise
        && s_nxt.mode == DIMC_SPI |=> $stable(dac_code)) else $error("spi code moved without frame");

    // mode decode: spi enable, then the stored option, then source select
    // the option is a stored level, so it is read here without a synchroniser
    chk_mode_spi: assert property (pins_s.spi_en
        |=> active_mode == DIMC_SPI) else $error("spi enable did not select spi");
    chk_mode_direct: assert property (!pins_s.spi_en && direct_serial_option
        |=> active_mode == DIMC_JTAG_DIRECT) else $error("stored option did not select direct mode");
    chk_mode_par: assert property (!pins_s.spi_en && !direct_serial_option && pins_s.src_sel
        |=> active_mode == DIMC_PARALLEL) else $error("source select high did not select parallel");
    chk_mode_nvm: assert property (!pins_s.spi_en && !direct_serial_option && !pins_s.src_sel
        |=> active_mode == DIMC_NVM) else $error("source select low did not select nonvolatile");

    // jtag direct: a complete word is applied, anything else leaves the code alone
    chk_direct_load: assert property (s_r.booted && load_evt && s_r.mode == DIMC_JTAG_DIRECT
        && !cs_rise |=> dac_code == $past(tup_r.word)) else $error("direct word not applied");
    chk_direct_hold: assert property (s_r.booted && s_r.mode == DIMC_JTAG_DIRECT && !load_evt
        |=> $stable(dac_code)) else $error("direct code moved without a load");

    // tck side: shift at the top on the rising edge, capture only a full word on the falling edge
    chk_jtag_shift: assert property (@(posedge tck) disable iff (tck_rst)
        jtag_shift_dr && direct_load_command |=> tsh_r.sr[7] == $past(tdi))
        else $error("jtag bit not shifted in at the top");
    chk_jtag_capture: assert property (@(negedge tck) disable iff (tck_rst)
        jtag_update_dr && direct_load_command && tsh_r.cnt == WORD_BITS |=> tup_r.word == $past(tsh_r.sr))
        else $error("full jtag word not captured");
    chk_jtag_short: assert property (@(negedge tck) disable iff (tck_rst)
        jtag_update_dr && tsh_r.cnt != WORD_BITS |=> $stable(tup_r.word))
        else $error("partial jtag word captured");
endmodule : dimc_ctrl

/* File: dimc_host.sv */
/*
 * host controller model: drives the parallel, spi and jtag ports of the converter control.
 * assumes: clk_sys comes from the bench; tck is made here and runs only in the reset burst and inside jtag frames.
 */
`timescale 1ns/1ps
// ------------------------------------------------------------
// host ports and transfer tasks
// ------------------------------------------------------------
module dimc_host (
    input  wire logic                        clk_sys,
    output logic                             tck,
    output logic                             tck_rst,
    output logic                             tdi,
    output logic                             shift_dr,
    output logic                             update_dr,
    output logic                             load_cmd,
    output logic                             prog_cmd,
    output logic                             cs,
    output logic                             sclk,
    output logic                             sdata,
    output logic [dimc_pkg::CODE_W-1:0]      data
);
    import dimc_pkg::*;

    // idle levels, then a short tck burst to clear the tck domain
    initial begin
        tck = 1'b0;
        tck_rst = 1'b1;
        tdi = 1'b0;
        shift_dr = 1'b0;
        update_dr = 1'b0;
        load_cmd = 1'b0;
        prog_cmd = 1'b0;
        cs = 1'b1;
        sclk = 1'b0;
        sdata = 1'b0;
        data = 8'h00;
        repeat (2) begin
            #32 tck = 1'b1;
            #32 tck = 1'b0;
        end
        #16 tck_rst = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // data settles, cs pulses low, its rising edge latches; pins then change so a stale hold shows
    task automatic par_write(input logic [7:0] d);
        data <= d;
        cyc(4);
        cs <= 1'b0;
        cyc(4);
        cs <= 1'b1;
        cyc(4);
        data <= ~d;
        cyc(1);
    endtask : par_write

    // one spi frame of n bits, lsb first; n other than 8 is a deliberately bad frame
    task automatic spi_frame(input logic [8:0] d, input int n);
        cs <= 1'b0;
        cyc(4);
        for (int i = 0; i < n; i++) begin
            sdata <= d[i];
            cyc(4);
            sclk <= 1'b1;
            cyc(4);
            sclk <= 1'b0;
        end
        cyc(4);
        cs <= 1'b1;
        sdata <= ~sdata;
        cyc(6);
    endtask : spi_frame

    // n shifts of d (lsb first) then one update-dr; prog picks the program command instead of load
    // tap levels move mid-phase, never in the time step of a tck edge, so no flop races them
    task automatic jtag_op(input logic [7:0] d, input int n, input logic prog);
        @(posedge clk_sys);
        #7;
        load_cmd = !prog;
        prog_cmd = prog;
        shift_dr = (n > 0);
        for (int i = 0; i < n; i++) begin
            tdi = d[i];
            #16 tck = 1'b1;
            #32 tck = 1'b0;
            #16;
        end
        // exit edge, then update-dr spans one falling edge and the rising edge that leaves it
        shift_dr = 1'b0;
        #16 tck = 1'b1;
        #16 update_dr = 1'b1;
        #16 tck = 1'b0;
        #32 tck = 1'b1;
        #16 update_dr = 1'b0;
        #16 tck = 1'b0;
        #16;
        load_cmd = 1'b0;
        prog_cmd = 1'b0;
        tdi = ~tdi;
    endtask : jtag_op
endmodule : dimc_host

/* File: dimc_ctrl_tb.sv */
/*
 * self-checking bench of the converter input mode control: walks all four modes.
 * assumes: the host model drives the port pins; the bench owns mode pins and the cell code.
 */
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module dimc_ctrl_tb;
    import dimc_pkg::*;
    localparam logic [7:0] CODES [4] = '{NEG_FS, MID_SCALE, POS_FS, 8'h7f};
    logic       clk_sys, srst, src_sel, spi_en, dso, tck, tck_rst, tdi, shift_dr, update_dr;
    logic       load_cmd, prog_cmd, cs, sclk, sdata, prog_req, refused;
    logic [7:0] data, nvm, dac_code, prog_data;
    dimc_mode_t mode;
    int         err_count, n_checks;

    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;

    dimc_host u_host (.clk_sys(clk_sys), .tck(tck), .tck_rst(tck_rst), .tdi(tdi), .shift_dr(shift_dr),
        .update_dr(update_dr), .load_cmd(load_cmd), .prog_cmd(prog_cmd), .cs(cs), .sclk(sclk),
        .sdata(sdata), .data(data));
    dimc_ctrl dut (.clk_sys(clk_sys), .srst(srst), .tck(tck), .tck_rst(tck_rst), .tdi(tdi),
        .jtag_shift_dr(shift_dr), .jtag_update_dr(update_dr), .direct_load_command(load_cmd),
        .nvm_program_command(prog_cmd), .direct_serial_option(dso), .dac_source_select_pin(src_sel),
        .serial_port_enable_pin(spi_en), .chip_select_pin(cs), .spi_clk_pin(sclk),
        .spi_data_pin(sdata), .data_bits(data), .nvm_stored_code(nvm), .dac_code(dac_code),
        .active_mode(mode), .nvm_prog_req(prog_req), .nvm_prog_data(prog_data),
        .nvm_prog_refused(refused));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_mode(input dimc_mode_t got, input dimc_mode_t exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t mode got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_mode

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t flag got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // waits a bounded time for the one-cycle program or refusal pulse, then judges it
    task automatic chk_prog(input logic exp_req, input logic [7:0] exp_d);
        int k;
        k = 0;
        while (prog_req !== 1'b1 && refused !== 1'b1 && k < 12) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (prog_req !== 1'b1 && refused !== 1'b1) begin
            err_count++;
            report_and_stop();
        end else begin
            chk_bit(prog_req, exp_req);
            chk_bit(refused, !exp_req);
            if (exp_req) chk_code(prog_data, exp_d);
        end
    endtask : chk_prog

    // this task moves the mode pins only while reset holds, so the boot sample sees them settled
    task automatic do_reset(input logic sp, input logic ss, input logic ds);
        srst <= 1'b1;
        spi_en <= sp;
        src_sel <= ss;
        dso <= ds;
        cyc(2);
        srst <= 1'b0;
        cyc(8);
    endtask : do_reset

    // main sequence: nonvolatile, parallel, spi, jtag direct, then power-up codes
    initial begin
        srst = 1'b1;
        src_sel = 1'b0;
        spi_en = 1'b0;
        dso = 1'b0;
        nvm = 8'h3c;
        err_count = 0;
        n_checks = 0;
        do_reset(1'b0, 1'b0, 1'b0);
        chk_code(dac_code, 8'h3c);
        chk_mode(mode, DIMC_NVM);
        nvm <= 8'hc3;
        cyc(3);
        chk_code(dac_code, 8'hc3);
        u_host.par_write(8'h11);
        u_host.jtag_op(8'h5a, 8, 1'b0);
        cyc(6);
        chk_code(dac_code, 8'hc3);
        u_host.jtag_op(8'h00, 0, 1'b1);
        chk_prog(1'b1, 8'h5a);
        src_sel <= 1'b1;
        cyc(4);
        chk_mode(mode, DIMC_PARALLEL);
        foreach (CODES[i]) begin
            u_host.par_write(CODES[i]);
            chk_code(dac_code, CODES[i]);
        end
        // this frame's chip select rise re-latches the pins, left at the inverse of 7f
        u_host.spi_frame(9'h0a5, 8);
        u_host.jtag_op(8'h33, 8, 1'b0);
        cyc(6);
        chk_code(dac_code, 8'h80);
        u_host.jtag_op(8'h00, 0, 1'b1);
        chk_prog(1'b1, 8'h80);
        spi_en <= 1'b1;
        cyc(4);
        chk_mode(mode, DIMC_SPI);
        u_host.spi_frame(9'h13c, 8);
        chk_code(dac_code, 8'h3c);
        u_host.spi_frame(9'h0f0, 7);
        chk_code(dac_code, 8'h3c);
        u_host.spi_frame(9'h1c3, 9);
        chk_code(dac_code, 8'h3c);
        u_host.spi_frame(9'h001, 8);
        chk_code(dac_code, 8'h01);
        nvm <= 8'h77;
        u_host.jtag_op(8'h44, 8, 1'b0);
        cyc(6);
        chk_code(dac_code, 8'h01);
        u_host.jtag_op(8'h00, 0, 1'b1);
        chk_prog(1'b0, 8'h00);
        do_reset(1'b0, 1'b1, 1'b1);
        chk_code(dac_code, MID_SCALE);
        chk_mode(mode, DIMC_JTAG_DIRECT);
        u_host.jtag_op(8'h96, 8, 1'b0);
        cyc(6);
        chk_code(dac_code, 8'h96);
        u_host.jtag_op(8'h0f, 7, 1'b0);
        cyc(6);
        chk_code(dac_code, 8'h96);
        u_host.jtag_op(8'h00, 0, 1'b1);
        chk_prog(1'b1, 8'h96);
        cyc(8);
        u_host.jtag_op(8'h69, 8, 1'b0);
        cyc(6);
        chk_code(dac_code, 8'h69);
        do_reset(1'b0, 1'b1, 1'b0);
        chk_code(dac_code, MID_SCALE);
        do_reset(1'b1, 1'b0, 1'b0);
        chk_code(dac_code, MID_SCALE);
        report_and_stop();
    end
endmodule : dimc_ctrl_tb
